// ===== core/agc_config_registers.sv
/*
  Byte-wide configuration bank for receive gain control and transmit power.
  Assumes a simple register port (read data one cycle after the strobe),
  the gain loop datapath on the same clock, and the power-enable pin async.
*/
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module agc_config_registers #(
  parameter int LUT_DEPTH = agc_cfg_pkg::LUT_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic transmit_power_enable_i,
  input wire logic loop_frozen_i,
  input wire logic loop_locked_i,
  input wire logic [3:0] lock_update_count_i,
  input wire logic second_power_lower_i,
  input wire logic [6:0] gain_voltage_i,
  input wire logic loop_rf_pad_remove_i,
  input wire logic [6:0] loop_if_gain_i,
  input wire logic [3:0] sat_count_i,
  input wire logic [3:0] mid_sat_count_i,
  input wire logic [3:0] low_sat_count_i,
  input wire logic [4:0] agc_level_i,
  input wire logic [4:0] lut_lookup_addr_i,
  output logic [6:0] lut_lookup_data_o,
  output logic [2:0] cw_scale_o,
  output logic cw_force_active_o,
  output logic cw_force_inactive_o,
  output logic [4:0] lock_in_level_o,
  output logic [4:0] lock_window_pos_o,
  output logic [5:0] lock_window_neg_o,
  output logic diversity_allowed_o,
  output logic [5:0] backoff_o,
  output logic [6:0] loop_gain_o,
  output logic rf_pad_control_line_o,
  output logic [6:0] if_gain_control_line_o,
  output logic gain_update_enable_o,
  output logic extra_update_enable_o,
  output logic second_antenna_abort_o,
  output logic sat_step_allow_o,
  output logic [4:0] mid_atten_step_o,
  output logic [3:0] low_atten_step_o,
  output logic [5:0] second_carrier_sense_scale_o,
  output logic [6:0] tx_power_dac_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] gain_lock_in_level;
  logic [7:0] gain_lock_window_positive;
  logic [7:0] gain_backoff;
  logic [7:0] gain_table_address;
  logic [7:0] gain_table_data;
  logic [7:0] gain_loop_gain;
  logic [7:0] gain_manual_override;
  logic [7:0] gain_test_modes;
  logic [7:0] rf_pad_threshold;
  logic [7:0] saturation_attenuation;
  logic [7:0] gain_lock_window_negative;
  logic [7:0] carrier_sense_two_scale;
  logic [7:0] transmit_power_level;
  // unused bits are stored as written; software keeps them zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gain_lock_in_level <= agc_cfg_pkg::REG_RESET;
      gain_lock_window_positive <= agc_cfg_pkg::REG_RESET;
      gain_backoff <= agc_cfg_pkg::REG_RESET;
      gain_table_address <= agc_cfg_pkg::REG_RESET;
      gain_table_data <= agc_cfg_pkg::REG_RESET;
      gain_loop_gain <= agc_cfg_pkg::REG_RESET;
      gain_manual_override <= agc_cfg_pkg::REG_RESET;
      gain_test_modes <= agc_cfg_pkg::REG_RESET;
      rf_pad_threshold <= agc_cfg_pkg::REG_RESET;
      saturation_attenuation <= agc_cfg_pkg::REG_RESET;
      gain_lock_window_negative <= agc_cfg_pkg::REG_RESET;
      carrier_sense_two_scale <= agc_cfg_pkg::REG_RESET;
      transmit_power_level <= agc_cfg_pkg::REG_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        agc_cfg_pkg::OFS_LOCK_IN: gain_lock_in_level <= reg_wdata_i;
        agc_cfg_pkg::OFS_WIN_POS: gain_lock_window_positive <= reg_wdata_i;
        agc_cfg_pkg::OFS_BACKOFF: gain_backoff <= reg_wdata_i;
        agc_cfg_pkg::OFS_TBL_ADDR: gain_table_address <= reg_wdata_i;
        agc_cfg_pkg::OFS_TBL_DATA: gain_table_data <= reg_wdata_i;
        agc_cfg_pkg::OFS_LOOP_GAIN: gain_loop_gain <= reg_wdata_i;
        agc_cfg_pkg::OFS_OVERRIDE: gain_manual_override <= reg_wdata_i;
        agc_cfg_pkg::OFS_TEST: gain_test_modes <= reg_wdata_i;
        agc_cfg_pkg::OFS_RF_THR: rf_pad_threshold <= reg_wdata_i;
        agc_cfg_pkg::OFS_SAT_ATT: saturation_attenuation <= reg_wdata_i;
        agc_cfg_pkg::OFS_WIN_NEG: gain_lock_window_negative <= reg_wdata_i;
        agc_cfg_pkg::OFS_CS2: carrier_sense_two_scale <= reg_wdata_i;
        agc_cfg_pkg::OFS_TX_PWR: transmit_power_level <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // gain lookup table
  // ----------------------------------------------------------------
  logic tbl_addr_wr;
  logic tbl_data_wr;
  logic [4:0] tbl_rd_addr;
  logic [6:0] tbl_rd_q;
  assign tbl_addr_wr = reg_wr_i && reg_addr_i == agc_cfg_pkg::OFS_TBL_ADDR;
  assign tbl_data_wr = reg_wr_i && reg_addr_i == agc_cfg_pkg::OFS_TBL_DATA;
  // look ahead on an address write so a read right after sees the new entry
  assign tbl_rd_addr = tbl_addr_wr ? reg_wdata_i[4:0] : gain_table_address[4:0];
  // table entries are written through the data register; value unsigned
  gain_lut_mem #(
    .DEPTH(LUT_DEPTH),
    .AW(agc_cfg_pkg::LUT_AW),
    .DW(agc_cfg_pkg::LUT_DW)
  ) u_lut (
    .clk_i(sys_clk_i),
    .we_i(tbl_data_wr),
    .waddr_i(gain_table_address[4:0]),
    .wdata_i(reg_wdata_i[6:0]),
    .raddr_a_i(tbl_rd_addr),
    .rdata_a_o(tbl_rd_q),
    .raddr_b_i(lut_lookup_addr_i),
    .rdata_b_o(lut_lookup_data_o)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = agc_cfg_pkg::RDATA_UNMAPPED;
    case (reg_addr_i)
      agc_cfg_pkg::OFS_LOCK_IN: next_rdata = gain_lock_in_level;
      agc_cfg_pkg::OFS_WIN_POS: next_rdata = gain_lock_window_positive;
      agc_cfg_pkg::OFS_BACKOFF: next_rdata = gain_backoff;
      agc_cfg_pkg::OFS_TBL_ADDR: next_rdata = gain_table_address;
      agc_cfg_pkg::OFS_TBL_DATA: begin
        if (gain_table_address[agc_cfg_pkg::TBL_READ_SEL_BIT]) begin
          next_rdata = {1'b0, tbl_rd_q};
        end else begin
          next_rdata = gain_table_data;
        end
      end
      agc_cfg_pkg::OFS_LOOP_GAIN: next_rdata = gain_loop_gain;
      agc_cfg_pkg::OFS_OVERRIDE: next_rdata = gain_manual_override;
      agc_cfg_pkg::OFS_TEST: next_rdata = gain_test_modes;
      agc_cfg_pkg::OFS_RF_THR: next_rdata = rf_pad_threshold;
      agc_cfg_pkg::OFS_SAT_ATT: next_rdata = saturation_attenuation;
      agc_cfg_pkg::OFS_WIN_NEG: next_rdata = gain_lock_window_negative;
      agc_cfg_pkg::OFS_CS2: next_rdata = carrier_sense_two_scale;
      agc_cfg_pkg::OFS_TX_PWR: next_rdata = transmit_power_level;
      default: next_rdata = agc_cfg_pkg::RDATA_UNMAPPED;
    endcase
  end

  // data stand for exactly the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // plain field outputs
  // ----------------------------------------------------------------
  assign cw_scale_o = gain_lock_in_level[7:agc_cfg_pkg::CW_SCALE_LSB];
  assign lock_in_level_o = gain_lock_in_level[4:0];
  assign lock_window_pos_o = gain_lock_window_positive[4:0];
  assign backoff_o = gain_backoff[5:0];
  assign loop_gain_o = gain_loop_gain[6:0];
  assign second_carrier_sense_scale_o = carrier_sense_two_scale[5:0];

  // ----------------------------------------------------------------
  // derived controls
  // ----------------------------------------------------------------
  logic ovr_en;
  logic rf_thr_remove;
  logic auto_rf;
  logic within_block;
  logic [4:0] block_level;
  logic next_sat_allow;
  assign ovr_en = gain_test_modes[agc_cfg_pkg::TEST_OVERRIDE_BIT];
  assign rf_thr_remove = !rf_pad_threshold[agc_cfg_pkg::RF_THR_DIS_BIT]
      && gain_voltage_i < rf_pad_threshold[6:0];
  assign auto_rf = loop_rf_pad_remove_i | rf_thr_remove;
  // block level is 1xx.x in half-dB units, 4.0 to 7.5
  assign block_level = {2'b01, gain_lock_window_negative[7:agc_cfg_pkg::SAT_BLOCK_LSB]};
  assign within_block = agc_level_i <= block_level;
  assign next_sat_allow = !within_block
      || gain_test_modes[agc_cfg_pkg::TEST_SAT_STEP_BIT];
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cw_force_active_o <= 1'b0;
      cw_force_inactive_o <= 1'b0;
      lock_window_neg_o <= 6'h00;
      diversity_allowed_o <= 1'b0;
    end else begin
      cw_force_active_o <= cw_scale_o == agc_cfg_pkg::CW_SCALE_ALWAYS_ON;
      cw_force_inactive_o <= cw_scale_o == agc_cfg_pkg::CW_SCALE_ALWAYS_OFF;
      lock_window_neg_o <= 6'(-{1'b0, gain_lock_window_negative[4:0]});
      diversity_allowed_o <= {1'b0, gain_lock_window_positive[7:agc_cfg_pkg::MAX_LOCK_LSB]}
          >= lock_update_count_i;
    end
  end

  // pad line: polarity applies to both manual and automatic sources
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rf_pad_control_line_o <= 1'b0;
      if_gain_control_line_o <= 7'h00;
    end else begin
      rf_pad_control_line_o <= gain_test_modes[agc_cfg_pkg::TEST_RF_POLARITY_BIT]
          ^ (ovr_en ? gain_manual_override[agc_cfg_pkg::OVR_RF_BIT] : auto_rf);
      if_gain_control_line_o <= ovr_en ? gain_manual_override[6:0] : loop_if_gain_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gain_update_enable_o <= 1'b0;
      extra_update_enable_o <= 1'b0;
      second_antenna_abort_o <= 1'b0;
    end else begin
      gain_update_enable_o <= !(loop_frozen_i || loop_locked_i)
          || gain_test_modes[agc_cfg_pkg::TEST_CONT_UPDATE_BIT];
      extra_update_enable_o <= !gain_test_modes[agc_cfg_pkg::TEST_EXTRA_DIS_BIT];
      second_antenna_abort_o <= gain_test_modes[agc_cfg_pkg::TEST_ANT_ABORT_BIT]
          && second_power_lower_i;
    end
  end

  // saturation steps only issue while the step is allowed
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sat_step_allow_o <= 1'b0;
      mid_atten_step_o <= 5'h00;
      low_atten_step_o <= 4'h0;
    end else begin
      sat_step_allow_o <= next_sat_allow;
      mid_atten_step_o <= (next_sat_allow && sat_count_i > mid_sat_count_i)
          ? {saturation_attenuation[7:agc_cfg_pkg::MID_ATT_LSB], 1'b0} : 5'h00;
      low_atten_step_o <= (next_sat_allow && sat_count_i > low_sat_count_i)
          ? saturation_attenuation[3:0] : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // transmit power
  // ----------------------------------------------------------------
  logic tx_en_level;
  logic tx_en_prev;
  logic tx_en_rise;
  pin_sync u_transmit_power_enable_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .pin_i(transmit_power_enable_i),
    .level_o(tx_en_level)
  );
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_prev <= 1'b0;
    end else begin
      tx_en_prev <= tx_en_level;
    end
  end
  assign tx_en_rise = tx_en_level && !tx_en_prev;
  // software may rewrite the word mid-burst without disturbing the DAC
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_power_dac_o <= 7'h00;
    end else if (tx_en_rise) begin
      tx_power_dac_o <= transmit_power_level[7:agc_cfg_pkg::TX_PWR_LSB];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);
  sequence s_rise;
    !tx_en_level ##1 tx_en_level;
  endsequence
  AST_TXPWR_LOAD: assert property (
    s_rise |=> tx_power_dac_o == $past(transmit_power_level[7:1]))
    else $error("power word not loaded on enable rise");
  AST_TXPWR_HOLD: assert property (
    !tx_en_rise |=> $stable(tx_power_dac_o))
    else $error("power word changed without enable rise");
  AST_TBL_READ: assert property (
    reg_rd_i && reg_addr_i == agc_cfg_pkg::OFS_TBL_DATA && !gain_table_address[5]
    |=> reg_rdata_o == $past(gain_table_data))
    else $error("table data register not returned");
  AST_OVR_IF: assert property (
    ovr_en |=> if_gain_control_line_o == $past(gain_manual_override[6:0]))
    else $error("override not driving IF gain");
  AST_OVR_RF: assert property (
    ovr_en |=> rf_pad_control_line_o == ($past(gain_test_modes[6]) ^ $past(gain_manual_override[7])))
    else $error("override pad level wrong");
  AST_FREEZE: assert property (
    loop_locked_i && !gain_test_modes[7] |=> !gain_update_enable_o)
    else $error("update enabled while locked");
  AST_NEG_WIN: assert property (
    ##1 6'(lock_window_neg_o + {1'b0, $past(gain_lock_window_negative[4:0])}) == 6'h00)
    else $error("negative window not negated");
  AST_DIVERSITY: assert property (
    lock_update_count_i > 4'h7 |=> !diversity_allowed_o)
    else $error("diversity allowed beyond count");
  AST_PAD_THR: assert property (
    !ovr_en && rf_pad_threshold[7] && !loop_rf_pad_remove_i
    |=> rf_pad_control_line_o == $past(gain_test_modes[6]))
    else $error("disabled threshold still removes pad");
  AST_SAT_BLOCK: assert property (
    within_block && !gain_test_modes[0] |=> mid_atten_step_o == 5'h00 && low_atten_step_o == 4'h0)
    else $error("sat step inside block window");
  AST_EXTRA: assert property (
    gain_test_modes[5] |=> !extra_update_enable_o)
    else $error("extra update not disabled");
endmodule : agc_config_registers
`default_nettype wire

// ===== core/agc_cfg_pkg.sv
/*
  Constants for the receive gain control configuration bank: byte offsets,
  field positions, reset values and lookup table geometry.
  Assumes an 8-bit register port with byte addresses as offsets.
*/
package agc_cfg_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOCK_IN = 8'h26;
  localparam logic [7:0] OFS_WIN_POS = 8'h28;
  localparam logic [7:0] OFS_BACKOFF = 8'h2a;
  localparam logic [7:0] OFS_TBL_ADDR = 8'h2c;
  localparam logic [7:0] OFS_TBL_DATA = 8'h2e;
  localparam logic [7:0] OFS_LOOP_GAIN = 8'h30;
  localparam logic [7:0] OFS_OVERRIDE = 8'h32;
  localparam logic [7:0] OFS_TEST = 8'h34;
  localparam logic [7:0] OFS_RF_THR = 8'h36;
  localparam logic [7:0] OFS_SAT_ATT = 8'h38;
  localparam logic [7:0] OFS_WIN_NEG = 8'h3a;
  localparam logic [7:0] OFS_CS2 = 8'h3c;
  localparam logic [7:0] OFS_TX_PWR = 8'h3e;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CW_SCALE_LSB = 5;
  localparam logic [2:0] CW_SCALE_ALWAYS_ON = 3'h0;
  localparam logic [2:0] CW_SCALE_ALWAYS_OFF = 3'h7;
  localparam int MAX_LOCK_LSB = 5;
  localparam int TBL_READ_SEL_BIT = 5;
  localparam int OVR_RF_BIT = 7;
  localparam int TEST_CONT_UPDATE_BIT = 7;
  localparam int TEST_RF_POLARITY_BIT = 6;
  localparam int TEST_EXTRA_DIS_BIT = 5;
  localparam int TEST_OVERRIDE_BIT = 2;
  localparam int TEST_ANT_ABORT_BIT = 1;
  localparam int TEST_SAT_STEP_BIT = 0;
  localparam int RF_THR_DIS_BIT = 7;
  localparam int MID_ATT_LSB = 4;
  localparam int SAT_BLOCK_LSB = 5;
  localparam int TX_PWR_LSB = 1;
  // ----------------------------------------------------------------
  // reset values and misc
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam int EXTRA_UPDATE_SAMPLES = 32;
  localparam int LUT_DEPTH = 32;
  localparam int LUT_AW = 5;
  localparam int LUT_DW = 7;
endpackage : agc_cfg_pkg

// ===== core/pin_sync.sv
/*
  Three-stage synchroniser for one pin; the filtered level changes once
  stages two and three agree. Assumes a synchronised active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], pin_i};
    end
  end

  // only stages two and three are compared; stage one is metastable-prone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_o <= stage[2];
    end
  end
endmodule : pin_sync
`default_nettype wire

// ===== core/gain_lut_mem.sv
/*
  Gain lookup table: one write port, two registered read ports.
  Assumes single clock; write-first when reading the address being written.
*/
`timescale 1ns/1ps
`default_nettype none
module gain_lut_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 7
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [DW-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [DW-1:0] rdata_b_o
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_a_o <= (we_i && waddr_i == raddr_a_i) ? wdata_i : mem[raddr_a_i];
    rdata_b_o <= (we_i && waddr_i == raddr_b_i) ? wdata_i : mem[raddr_b_i];
  end
endmodule : gain_lut_mem
`default_nettype wire

// ===== dv/host_bus_model.sv
/*
  Control bus master standing in for host software.
  Assumes the slave answers a read one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // released data must not look valid
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    // data stand in the cycle after the strobe; taken before this edge clears them
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ===== dv/test_agc_config_registers.sv
/*
  Self-checking bench for the gain control configuration bank.
  Assumes host_bus_model as bus master and the package offsets.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_agc_config_registers;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd;
  logic transmit_power_enable = 0, frozen = 0, locked = 0, lower = 0, pad_rm = 0;
  logic [3:0] upd = 0, sat = 0, mid = 0, low = 0;
  logic [6:0] volt = 0, loop_if = 0;
  logic [4:0] level = 0, lut_a = 0;
  wire logic [6:0] lut_d, lgain, if_g, dac;
  wire logic [5:0] win_neg, backoff, cs2;
  wire logic [4:0] lock_in, win_pos, mid_st;
  wire logic [3:0] low_st;
  wire logic [2:0] cw_scale;
  wire logic cw_on, cw_off, div, rf, upd_en, extra_en, abort, sat_ok;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] d;
  always #10 sys_clk_i = ~sys_clk_i;
  host_bus_model host (.clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  agc_config_registers uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .transmit_power_enable_i(transmit_power_enable), .loop_frozen_i(frozen),
    .loop_locked_i(locked), .lock_update_count_i(upd), .second_power_lower_i(lower),
    .gain_voltage_i(volt), .loop_rf_pad_remove_i(pad_rm), .loop_if_gain_i(loop_if),
    .sat_count_i(sat), .mid_sat_count_i(mid), .low_sat_count_i(low),
    .agc_level_i(level), .lut_lookup_addr_i(lut_a), .lut_lookup_data_o(lut_d),
    .cw_scale_o(cw_scale), .cw_force_active_o(cw_on), .cw_force_inactive_o(cw_off),
    .lock_in_level_o(lock_in), .lock_window_pos_o(win_pos), .lock_window_neg_o(win_neg),
    .diversity_allowed_o(div), .backoff_o(backoff), .loop_gain_o(lgain),
    .rf_pad_control_line_o(rf), .if_gain_control_line_o(if_g),
    .gain_update_enable_o(upd_en), .extra_update_enable_o(extra_en),
    .second_antenna_abort_o(abort), .sat_step_allow_o(sat_ok),
    .mid_atten_step_o(mid_st), .low_atten_step_o(low_st),
    .second_carrier_sense_scale_o(cs2), .tx_power_dac_o(dac));
  // nibble swap keeps table read select (bit 5) clear at 0x2c
  function automatic logic [7:0] pat(input logic [7:0] a);
    return {a[3:0], a[7:4]};
  endfunction : pat
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    `CHK("rdata", e, d)
  endtask : rchk
  task automatic settle();
    // checks run in the edge's time step and see what stood before it
    repeat (3) @(posedge sys_clk_i);
  endtask : settle
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 13; i++) rchk(8'h26 + 8'(2 * i), 8'h00);
    rchk(8'h27, 8'h00);
    `CHK("cw_on", 1'b1, cw_on)
    `CHK("extra", 1'b1, extra_en)
    for (int i = 0; i < 13; i++) host.wr(8'h26 + 8'(2 * i), pat(8'h26 + 8'(2 * i)));
    host.wr(8'h27, 8'hff);
    for (int i = 0; i < 13; i++) rchk(8'h26 + 8'(2 * i), pat(8'h26 + 8'(2 * i)));
    rchk(8'h27, 8'h00);
    upd <= 4'h4;
    settle();
    `CHK("cw", 3'h3, cw_scale)
    `CHK("lockin", 5'h02, lock_in)
    `CHK("div", 1'b1, div)
    `CHK("winpos", 5'h02, win_pos)
    `CHK("backoff", 6'h22, backoff)
    `CHK("lgain", 7'h03, lgain)
    `CHK("winneg", 6'h3d, win_neg)
    `CHK("cs2", 6'h03, cs2)
    `CHK("dac", 7'h00, dac)
    upd <= 4'h5;
    host.wr(8'h26, 8'he0);
    settle();
    `CHK("div", 1'b0, div)
    `CHK("cw_off", 1'b1, cw_off)
    `CHK("cw_on", 1'b0, cw_on)
    host.wr(8'h28, 8'he2);
    upd <= 4'h7;
    settle();
    `CHK("div", 1'b1, div)
    upd <= 4'h8;
    settle();
    `CHK("div", 1'b0, div)
    host.wr(8'h34, 8'h00);
    locked <= 1'b1;
    lower <= 1'b1;
    settle();
    `CHK("upd", 1'b0, upd_en)
    `CHK("abort", 1'b0, abort)
    locked <= 1'b0;
    frozen <= 1'b1;
    settle();
    `CHK("upd", 1'b0, upd_en)
    host.wr(8'h34, 8'ha2);
    settle();
    `CHK("upd", 1'b1, upd_en)
    `CHK("extra", 1'b0, extra_en)
    `CHK("abort", 1'b1, abort)
    loop_if <= 7'h2a;
    host.wr(8'h32, 8'h85);
    host.wr(8'h34, 8'h04);
    settle();
    `CHK("ifg", 7'h05, if_g)
    `CHK("rf", 1'b1, rf)
    host.wr(8'h34, 8'h44);
    settle();
    `CHK("rf", 1'b0, rf)
    host.wr(8'h36, 8'h20);
    host.wr(8'h34, 8'h00);
    volt <= 7'h1f;
    settle();
    `CHK("ifg", 7'h2a, if_g)
    `CHK("rf", 1'b1, rf)
    volt <= 7'h20;
    settle();
    `CHK("rf", 1'b0, rf)
    host.wr(8'h36, 8'ha0);
    volt <= 7'h1f;
    settle();
    `CHK("rf", 1'b0, rf)
    pad_rm <= 1'b1;
    settle();
    `CHK("rf", 1'b1, rf)
    pad_rm <= 1'b0;
    host.wr(8'h3a, 8'h05);
    host.wr(8'h38, 8'h73);
    sat <= 4'h9;
    mid <= 4'h8;
    low <= 4'h9;
    level <= 5'h08;
    settle();
    `CHK("winneg", 6'h3b, win_neg)
    `CHK("satok", 1'b0, sat_ok)
    `CHK("mid", 5'h00, mid_st)
    level <= 5'h09;
    settle();
    `CHK("mid", 5'h0e, mid_st)
    `CHK("low", 4'h0, low_st)
    low <= 4'h8;
    level <= 5'h08;
    host.wr(8'h34, 8'h01);
    settle();
    `CHK("satok", 1'b1, sat_ok)
    `CHK("low", 4'h3, low_st)
    for (int a = 0; a < 32; a++) begin
      host.wr(8'h2c, 8'h20 | 8'(a));
      host.wr(8'h2e, 8'h80 | 8'(a * 3 + 1));
    end
    for (int a = 0; a < 32; a++) begin
      host.wr(8'h2c, 8'h20 | 8'(a));
      rchk(8'h2e, 8'(a * 3 + 1) & 8'h7f);
      lut_a <= 5'(a);
      settle();
      `CHK("lut", 7'(a * 3 + 1), lut_d)
    end
    host.wr(8'h2c, 8'h1f);
    rchk(8'h2e, 8'h80 | 8'(31 * 3 + 1));
    host.wr(8'h3e, 8'h81);
    settle();
    `CHK("dac", 7'h00, dac)
    transmit_power_enable <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    `CHK("dac", 7'h40, dac)
    host.wr(8'h3e, 8'hfe);
    settle();
    `CHK("dac", 7'h40, dac)
    transmit_power_enable <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    transmit_power_enable <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    `CHK("dac", 7'h7f, dac)
    summarize();
  end
endmodule : test_agc_config_registers
`default_nettype wire
